// ===== rtl/lsc_regs_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef LSC_REGS_MAP_SVH
`define LSC_REGS_MAP_SVH
`define LSC_OFF_ENABLE     5'h00
`define LSC_OFF_ITIME      5'h01
`define LSC_OFF_WAIT_TIME      5'h03
`define LSC_OFF_LOW_LO     5'h04
`define LSC_OFF_LOW_HI     5'h05
`define LSC_OFF_HIGH_LO    5'h06
`define LSC_OFF_HIGH_HI    5'h07
`define LSC_OFF_CONFIG     5'h0D
`define LSC_OFF_STATUS     5'h13
`define LSC_OFF_RES_LO     5'h14
`define LSC_OFF_RES_HI     5'h15
`define LSC_BIT_PON        0
`define LSC_BIT_AEN        1
`define LSC_BIT_WEN        3
`define LSC_BIT_IRQ_MASK   4
`define LSC_BIT_SAI        6
`define LSC_BIT_WAIT_LONG_BIT      1
`define LSC_ENABLE_WMASK   8'h5B
`define LSC_CONFIG_WMASK   8'h06
`define LSC_RST_ENABLE     8'h00
`define LSC_RST_TIME       8'hFF
`define LSC_RST_THRESH     8'h00
`define LSC_RST_CONFIG     8'h00
`define LSC_TYPE_AUTOINC   2'h1
`define LSC_TYPE_SPECIAL   2'h3
`define LSC_SF_IRQ_CLEAR   5'h06
`define LSC_STEP_NS        2730000
`define LSC_CLK_NS         10
`define LSC_MAX_STEP_CNT   11'h400
`define LSC_RESULT_MAX     16'hFFFF
`define LSC_LONG_FACTOR    4'hC
`endif

// ===== rtl/lsc_pkg.sv
// types shared by the light sensor control block
package lsc_pkg;
   typedef enum logic [1:0] {
      LSC_IDLE  = 2'b00,
      LSC_INTEG = 2'b01,
      LSC_WAIT  = 2'b11
   } lsc_state_t;

   typedef struct packed {
      logic       select;
      logic [1:0] xfer_type;
      logic [4:0] addr;
   } lsc_cmd_t;
endpackage

// ===== rtl/lsc_regs.sv
// control, timing and threshold registers with measurement sequencer
`timescale 1ns/10ps
`default_nettype none
`include "lsc_regs_map.svh"

//Function
//- power-on bit runs the internal timebase; clearing it stops everything
//- measurement enable bit starts the converter cycle; zero disables it
//- enable register at 0x00 gates power and interrupts; mask bit 4 permits them
//- integration lasts 256 minus register value steps of 2.73 ms
//- integration time register resets to 0xFF, one step
//- each step adds at most 1024 counts; result saturates at 65535
//- wait steps are 2.73 ms, twelve times longer with wait-long set
//- wait steps number 256 minus the wait register value
//- wait time register resets to 0xFF, one step
//- interrupt when channel zero result is below low or above high threshold
//- thresholds sit at 0x04..0x07 as low then high, lower byte first
//- comparison uses channel zero only
//- a command byte selects the register later data bytes access
//- wait-long bit lives in the configuration register beside gain
module lsc_regs
   import lsc_pkg::*;
#(
   parameter int STEP_CYC = `LSC_STEP_NS / `LSC_CLK_NS
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        wr_stb_i,
   input  wire logic        wr_cmd_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        rd_stb_i,
   output logic      [7:0]  rd_data_o,
   input  wire logic [10:0] ch0_counts_i,
   output logic             osc_run_o,
   output logic             adc_en_o,
   output logic             irq_o
);

   lsc_state_t  state_r;
   lsc_cmd_t    cmd_r;
   logic [7:0]  enable_r, itime_r, wait_time_r, config_r;
   logic [15:0] low_thr_r, high_thr_r, result_r, acc_r;
   logic [18:0] div_r;
   logic [8:0]  steps_r;
   logic [3:0]  long_r;
   logic        irq_r, valid_r;
   logic        tick, end_cyc, out_range, irq_event, sleep_now, data_wr, sf_clear;
   logic [10:0] step_cnt;
   logic [16:0] acc_sum;
   logic [15:0] acc_nxt;

   function automatic logic [8:0] steps_of(input logic [7:0] v);
      steps_of = 9'h100 - {1'b0, v};
   endfunction

   // host side of the command/data protocol
   assign data_wr  = wr_stb_i && !wr_cmd_i;
   assign sf_clear = wr_stb_i && wr_cmd_i && wr_data_i[7] &&
                     wr_data_i[6:5] == `LSC_TYPE_SPECIAL &&
                     wr_data_i[4:0] == `LSC_SF_IRQ_CLEAR;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cmd_r <= '0;
      end else if (wr_stb_i && wr_cmd_i && wr_data_i[7] &&
                   wr_data_i[6:5] != `LSC_TYPE_SPECIAL) begin
         cmd_r <= lsc_cmd_t'(wr_data_i);
      end else if ((data_wr || rd_stb_i) && cmd_r.xfer_type == `LSC_TYPE_AUTOINC) begin
         cmd_r.addr <= cmd_r.addr + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         enable_r   <= `LSC_RST_ENABLE;
         itime_r    <= `LSC_RST_TIME;
         wait_time_r    <= `LSC_RST_TIME;
         config_r   <= `LSC_RST_CONFIG;
         low_thr_r  <= {2{`LSC_RST_THRESH}};
         high_thr_r <= {2{`LSC_RST_THRESH}};
      end else if (data_wr) begin
         if (cmd_r.addr == `LSC_OFF_ENABLE) begin
            enable_r <= wr_data_i & `LSC_ENABLE_WMASK;
         end else if (cmd_r.addr == `LSC_OFF_ITIME) begin
            itime_r <= wr_data_i;
         end else if (cmd_r.addr == `LSC_OFF_WAIT_TIME) begin
            wait_time_r <= wr_data_i;
         end else if (cmd_r.addr == `LSC_OFF_LOW_LO) begin
            low_thr_r[7:0] <= wr_data_i;
         end else if (cmd_r.addr == `LSC_OFF_LOW_HI) begin
            low_thr_r[15:8] <= wr_data_i;
         end else if (cmd_r.addr == `LSC_OFF_HIGH_LO) begin
            high_thr_r[7:0] <= wr_data_i;
         end else if (cmd_r.addr == `LSC_OFF_HIGH_HI) begin
            high_thr_r[15:8] <= wr_data_i;
         end else if (cmd_r.addr == `LSC_OFF_CONFIG) begin
            config_r <= wr_data_i & `LSC_CONFIG_WMASK;
         end
      end else if (sleep_now) begin
         enable_r[`LSC_BIT_PON] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_stb_i) begin
         if (cmd_r.addr == `LSC_OFF_ENABLE) begin
            rd_data_o <= enable_r;
         end else if (cmd_r.addr == `LSC_OFF_ITIME) begin
            rd_data_o <= itime_r;
         end else if (cmd_r.addr == `LSC_OFF_WAIT_TIME) begin
            rd_data_o <= wait_time_r;
         end else if (cmd_r.addr == `LSC_OFF_LOW_LO) begin
            rd_data_o <= low_thr_r[7:0];
         end else if (cmd_r.addr == `LSC_OFF_LOW_HI) begin
            rd_data_o <= low_thr_r[15:8];
         end else if (cmd_r.addr == `LSC_OFF_HIGH_LO) begin
            rd_data_o <= high_thr_r[7:0];
         end else if (cmd_r.addr == `LSC_OFF_HIGH_HI) begin
            rd_data_o <= high_thr_r[15:8];
         end else if (cmd_r.addr == `LSC_OFF_CONFIG) begin
            rd_data_o <= config_r;
         end else if (cmd_r.addr == `LSC_OFF_STATUS) begin
            rd_data_o <= {3'h0, irq_r, 3'h0, valid_r};
         end else if (cmd_r.addr == `LSC_OFF_RES_LO) begin
            rd_data_o <= result_r[7:0];
         end else if (cmd_r.addr == `LSC_OFF_RES_HI) begin
            rd_data_o <= result_r[15:8];
         end else begin
            rd_data_o <= 8'h00;
         end
      end
   end

   // timebase: one enable pulse per 2.73 ms step, only while powered
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !enable_r[`LSC_BIT_PON]) begin
         div_r <= '0;
      end else if (div_r == 19'(STEP_CYC - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 19'h00001;
      end
   end
   assign tick = enable_r[`LSC_BIT_PON] && div_r == 19'(STEP_CYC - 1);

   // per-step contribution clamps to the converter's full scale
   assign step_cnt = (ch0_counts_i > `LSC_MAX_STEP_CNT) ? `LSC_MAX_STEP_CNT
                                                        : ch0_counts_i;
   assign acc_sum  = {1'b0, acc_r} + {6'h00, step_cnt};
   assign acc_nxt  = acc_sum[16] ? `LSC_RESULT_MAX : acc_sum[15:0];
   assign end_cyc  = state_r == LSC_INTEG && tick &&
                     steps_r == steps_of(itime_r) - 9'h001;
   assign out_range = acc_nxt < low_thr_r || acc_nxt > high_thr_r;
   assign irq_event = end_cyc && out_range && enable_r[`LSC_BIT_IRQ_MASK];
   assign sleep_now = irq_event && enable_r[`LSC_BIT_SAI];

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !enable_r[`LSC_BIT_PON] || !enable_r[`LSC_BIT_AEN]) begin
         state_r <= LSC_IDLE;
         steps_r <= '0;
         long_r  <= '0;
         acc_r   <= '0;
      end else begin
         case (state_r)
            LSC_IDLE: begin
               state_r <= LSC_INTEG;
            end
            LSC_INTEG: begin
               if (end_cyc) begin
                  acc_r   <= '0;
                  steps_r <= '0;
                  if (sleep_now) begin
                     state_r <= LSC_IDLE;
                  end else if (enable_r[`LSC_BIT_WEN]) begin
                     state_r <= LSC_WAIT;
                  end
               end else if (tick) begin
                  acc_r   <= acc_nxt;
                  steps_r <= steps_r + 9'h001;
               end
            end
            LSC_WAIT: begin
               if (tick) begin
                  if (config_r[`LSC_BIT_WAIT_LONG_BIT] && long_r != `LSC_LONG_FACTOR - 4'h1) begin
                     long_r <= long_r + 4'h1;
                  end else if (steps_r == steps_of(wait_time_r) - 9'h001) begin
                     long_r  <= '0;
                     steps_r <= '0;
                     state_r <= LSC_INTEG;
                  end else begin
                     long_r  <= '0;
                     steps_r <= steps_r + 9'h001;
                  end
               end
            end
            default: state_r <= LSC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         result_r <= '0;
         valid_r  <= 1'b0;
      end else if (end_cyc) begin
         result_r <= acc_nxt;
         valid_r  <= 1'b1;
      end
   end

   // set wins over the special-function clear
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_r <= 1'b0;
      end else if (irq_event) begin
         irq_r <= 1'b1;
      end else if (sf_clear) begin
         irq_r <= 1'b0;
      end
   end

   assign osc_run_o = enable_r[`LSC_BIT_PON];
   assign adc_en_o  = state_r == LSC_INTEG;
   assign irq_o     = irq_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_cycle_done;
      end_cyc && out_range && enable_r[`LSC_BIT_IRQ_MASK];
   endsequence

   a_osc_gates_tick: assert property (!enable_r[`LSC_BIT_PON] |-> !tick ##1 div_r == '0)
      else $error("timebase ran while powered off");
   a_off_goes_idle: assert property (!enable_r[`LSC_BIT_AEN] |=> state_r == LSC_IDLE)
      else $error("sequencer active with measurement disabled");
   a_irq_masked: assert property ($rose(irq_r) |-> $past(enable_r[`LSC_BIT_IRQ_MASK]))
      else $error("interrupt raised while masked");
   a_wait_needs_en: assert property ($rose(state_r == LSC_WAIT) |-> $past(enable_r[`LSC_BIT_WEN]))
      else $error("wait entered with wait disabled");
   a_sleep_irq: assert property (s_cycle_done ##0 (enable_r[`LSC_BIT_SAI] && !data_wr) |=> !enable_r[`LSC_BIT_PON])
      else $error("no power down after interrupt");
   a_integ_length: assert property (end_cyc |-> steps_r == 9'h0FF - {1'b0, itime_r})
      else $error("integration length wrong");
   a_time_reset: assert property ($past(!reset_n_i) |-> itime_r == 8'hFF && wait_time_r == 8'hFF)
      else $error("time registers not 0xFF after reset");
   a_step_clamp: assert property (state_r == LSC_INTEG && tick && !end_cyc |=> {1'b0, acc_r} <= {1'b0, $past(acc_r)} + 17'h00400)
      else $error("step added more than full scale");
   a_irq_cause: assert property (s_cycle_done |=> irq_r)
      else $error("out of range result gave no interrupt");
   a_irq_only_range: assert property ($rose(irq_r) |-> $past(end_cyc && out_range))
      else $error("interrupt without out of range result");

endmodule
`default_nettype wire

// ===== verification/lsc_host_model.sv
// host-side byte link model: command byte, then data bytes
`timescale 1ns/10ps
`default_nettype none
module lsc_host_model (
   input  wire logic       clk_i,
   output logic            wr_stb_o,
   output logic            wr_cmd_o,
   output logic      [7:0] wr_data_o,
   output logic            rd_stb_o,
   input  wire logic [7:0] rd_data_i
);
   initial begin
      wr_stb_o = 1'b0;
      wr_cmd_o = 1'b0;
      wr_data_o = 8'h00;
      rd_stb_o = 1'b0;
   end
   // idle edge after each byte so a strobe never toggles twice in one step
   task automatic put(input logic c, input logic [7:0] d);
      wr_stb_o <= 1'b1;
      wr_cmd_o <= c;
      wr_data_o <= d;
      @(posedge clk_i);
      wr_stb_o <= 1'b0;
      wr_data_o <= ~d; // released bus must not keep showing old data
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      put(1'b1, {3'b100, a});
      put(1'b0, d);
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      put(1'b1, {3'b100, a});
      rd_stb_o <= 1'b1;
      @(posedge clk_i);
      rd_stb_o <= 1'b0;
      @(posedge clk_i);
      d = rd_data_i;
   endtask
endmodule
`default_nettype wire

// ===== verification/tb_light_sensor_control_regs.sv
// self-checking bench for the light sensor control registers
`timescale 1ns/10ps
`default_nettype none
module tb_light_sensor_control_regs;
   localparam int STEP = 20;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        wr_stb, wr_cmd, rd_stb, osc_run, adc_en, irq;
   logic [7:0]  wr_data, rd_data, v, lo, hi;
   logic [7:0]  seed = 8'h5B;
   logic [10:0] ch0 = 11'h000;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          k, n;
   int          exp_reg [0:31];

   always #5 clk_i = ~clk_i;

   lsc_host_model i_host (.clk_i(clk_i), .wr_stb_o(wr_stb), .wr_cmd_o(wr_cmd),
      .wr_data_o(wr_data), .rd_stb_o(rd_stb), .rd_data_i(rd_data));
   lsc_regs #(.STEP_CYC(STEP)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .wr_stb_i(wr_stb), .wr_cmd_i(wr_cmd), .wr_data_i(wr_data), .rd_stb_i(rd_stb),
      .rd_data_o(rd_data), .ch0_counts_i(ch0), .osc_run_o(osc_run), .adc_en_o(adc_en),
      .irq_o(irq));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic finish_test();
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // reserved enable bits are not stored
   task automatic mwr(input int a, input logic [7:0] d);
      i_host.wr(5'(a), d);
      exp_reg[a] = (a == 0) ? int'(d & 8'h5B) : int'(d);
   endtask
   task automatic mchk(input int a);
      i_host.rd(5'(a), v);
      check("register", 16'(v), 16'(exp_reg[a]));
   endtask
   task automatic wait_irq();
      k = 0;
      while (irq !== 1'b1 && k < 200) begin
         @(posedge clk_i);
         k++;
      end
   endtask
   task automatic clear_irq();
      mwr(0, 8'h00);
      i_host.put(1'b1, 8'hE6);
      check("cleared irq", 16'(irq), 16'h0000);
   endtask

   // generous ceiling: whole sequence needs under a thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      exp_reg = '{default: 0};
      exp_reg[1] = 255;
      exp_reg[3] = 255;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      check("reset outputs", {13'h0000, osc_run, adc_en, irq}, 16'h0000);
      for (int a = 0; a < 8; a++) mchk(a);
      i_host.wr(5'h02, 8'hA5);
      mchk(2);
      mwr(0, 8'hFF);
      mchk(0);
      check("power", 16'(osc_run), 16'h0001);
      mwr(0, 8'h00);
      check("power", 16'(osc_run), 16'h0000);
      i_host.put(1'b1, 8'hA4);
      for (int a = 4; a < 8; a++) begin
         seed = lfsr(seed);
         i_host.put(1'b0, seed);
         exp_reg[a] = int'(seed);
      end
      for (int a = 4; a < 8; a++) mchk(a);
      mwr(3, 8'hFE);
      mwr(1, 8'hFE);
      for (int a = 4; a < 8; a++) mwr(a, (a == 5) ? 8'h01 : (a == 7) ? 8'h02 : 8'h00);
      ch0 <= 11'h7FF;
      mwr(0, 8'h03);
      repeat (100) @(posedge clk_i);
      check("masked irq", 16'(irq), 16'h0000);
      check("integrating", 16'(adc_en), 16'h0001);
      i_host.rd(5'h14, lo);
      i_host.rd(5'h15, hi);
      check("result", {hi, lo}, 16'h0800);
      mwr(0, 8'h13);
      wait_irq();
      check("high irq", 16'(irq), 16'h0001);
      i_host.rd(5'h13, v);
      check("status irq", 16'(v[4]), 16'h0001);
      clear_irq();
      ch0 <= 11'h000;
      mwr(0, 8'h13);
      wait_irq();
      check("low irq", 16'(irq), 16'h0001);
      clear_irq();
      mwr(0, 8'h01);
      repeat (60) @(posedge clk_i);
      check("stopped", 16'(adc_en), 16'h0000);
      mwr(0, 8'h53);
      wait_irq();
      repeat (3) @(posedge clk_i);
      check("sleep", 16'(osc_run), 16'h0000);
      clear_irq();
      for (int l = 0; l < 2; l++) begin
         mwr(13, (l == 1) ? 8'h02 : 8'h00);
         mwr(3, (l == 1) ? 8'hFF : 8'hFE);
         mwr(0, 8'h0B);
         n = 0;
         // sequencer may still be idle right after the enable write
         while (adc_en !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
         end
         n = 0;
         while (adc_en !== 1'b0 && n < 400) begin
            @(negedge clk_i);
            n++;
         end
         n = 0;
         while (adc_en !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
         end
         k = (l == 1) ? 12 * STEP : 2 * STEP;
         check("wait length", 16'(n > k - 3 && n < k + 3), 16'h0001);
         @(posedge clk_i);
         mwr(0, 8'h00);
      end
      finish_test();
   end
endmodule
`default_nettype wire
